// ---- hdl/rtc_timer_alarm_core.sv ----
// real-time timer with snapshot/load bytes, alarm and oscillator control
// assumes software reaches registers through an index/data byte pair
//
// Contract
// - timer counts each slow tick while run set
// - load and snapshot work while timer runs
// - load strobe copies snapshot bytes into timer
// - hardware clears load strobe after load
// - lowest snapshot bit ignored on load
// - snapshot strobe copies timer, bit0 at bit1
// - snapshot strobe self-clears; software polls it
// - alarm compares timer with 47-bit target
// - alarm event when timer at or above target
// - alarm requests interrupt when enabled
// - alarm resets MCU when selected
// - alarm wakes internal oscillator
// - alarm yields interrupt, reset or wake
`timescale 1ns/100ps
`include "rtc_params.svh"

module rtc_timer_alarm_core #(
    parameter int DIV = `RTC_DIV
) (
    input  wire logic          clk_in,
    input  wire logic          arst_n_in,
    input  wire logic          index_wr_in,
    input  wire rtc_pkg::byte_t index_in,
    input  wire logic          data_wr_in,
    input  wire rtc_pkg::byte_t data_in,
    output rtc_pkg::byte_t     data_out,
    input  wire logic          irq_enable_in,
    input  wire logic          reset_source_in,
    input  wire logic          osc_valid_in,
    input  wire logic          backup_supply_in,
    output logic               rtc_enable_out,
    output logic               gain_control_enable_out,
    output logic               crystal_select_out,
    output logic               bias_double_out,
    output logic               irq_req_out,
    output logic               mcu_reset_out,
    output logic               osc_wake_out
);
    import rtc_pkg::*;

    typedef struct packed {
        byte_t      idx;
        logic       en;
        logic       mclk;
        logic       run;
        logic       aen;
        logic       flag;
        logic       load;
        logic       snap;
        logic       agc;
        logic       xtal;
        logic       bias;
        logic [2:0] sync_v;
        logic [2:0] sync_b;
        logic       valid_f;
        logic       vbat_f;
        byte_bank_t cap;
        byte_bank_t alm;
        byte_t      rdata;
        logic       alarm_evt;
    } core_state_t;

    core_state_t s_reg;
    core_state_t s_next;
    logic [1:0]  rst_sync_reg;
    logic        rst_n;
    logic        tick;
    timer_val_t  timer_val;
    logic [47:0] cap_flat;
    logic [47:0] alm_flat;
    logic        alarm_hit;

    // ==================================================
    // reset release
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ==================================================
    // timer
    assign cap_flat = s_reg.cap;
    assign alm_flat = s_reg.alm;

    rtc_tick_timer #(
        .DIV (DIV)
    ) u_timer (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n),
        .run_in      (s_reg.run),
        .load_in     (s_reg.load),
        .load_val_in (cap_flat[47:1]),
        .tick_out    (tick),
        .count_out   (timer_val)
    );

    // greater-or-equal, so a late enable still fires
    assign alarm_hit = s_reg.aen && (timer_val >= alm_flat[47:1]);

    // ==================================================
    // next state
    always_comb begin
        s_next = s_reg;
        // first stage feeds only the second
        s_next.sync_v = {s_reg.sync_v[1:0], osc_valid_in};
        s_next.sync_b = {s_reg.sync_b[1:0], backup_supply_in};
        if (s_reg.sync_v[2] == s_reg.sync_v[1]) begin
            s_next.valid_f = s_reg.sync_v[2];
        end
        if (s_reg.sync_b[2] == s_reg.sync_b[1]) begin
            s_next.vbat_f = s_reg.sync_b[2];
        end
        if (index_wr_in) begin
            s_next.idx = index_in;
        end
        if (data_wr_in) begin
            case (s_reg.idx)
                `RTC_ADR_CTRL: begin
                    s_next.en   = data_in[`RTC_CTL_EN];
                    s_next.mclk = data_in[`RTC_CTL_MCLK];
                    s_next.run  = data_in[`RTC_CTL_RUN];
                    s_next.aen  = data_in[`RTC_CTL_AEN];
                    if (!data_in[`RTC_CTL_FLAG]) begin
                        s_next.flag = 1'b0;
                    end
                    // strobes: writing zero never cancels
                    if (data_in[`RTC_CTL_LOAD]) begin
                        s_next.load = 1'b1;
                    end
                    if (data_in[`RTC_CTL_SNAP]) begin
                        s_next.snap = 1'b1;
                    end
                end
                `RTC_ADR_OSC: begin
                    s_next.agc  = data_in[`RTC_OSC_AGC];
                    s_next.xtal = data_in[`RTC_OSC_XTAL];
                    s_next.bias = data_in[`RTC_OSC_BIAS];
                end
                default: begin
                    for (int i = 0; i < `RTC_NBYTES; i++) begin
                        if (s_reg.idx == `RTC_ADR_CAP0 + 8'(i)) begin
                            s_next.cap[i] = data_in;
                        end
                        if (s_reg.idx == `RTC_ADR_ALM0 + 8'(i)) begin
                            s_next.alm[i] = data_in;
                        end
                    end
                end
            endcase
        end
        // transfers happen on the slow tick; timer keeps running
        if (tick) begin
            if (s_reg.load) begin
                s_next.load = 1'b0;
            end
            if (s_reg.snap) begin
                s_next.cap  = byte_bank_t'({timer_val, 1'b0});
                s_next.snap = 1'b0;
            end
        end
        // set wins over a clear in the same cycle
        s_next.alarm_evt = alarm_hit;
        if (alarm_hit) begin
            s_next.flag = 1'b1;
        end
        // read data lags the index by one cycle
        s_next.rdata = `RTC_ZERO_BYTE;
        case (s_reg.idx)
            `RTC_ADR_CTRL: begin
                s_next.rdata = {s_reg.en, s_reg.mclk, 1'b0, s_reg.run,
                                s_reg.aen, s_reg.flag, s_reg.load,
                                s_reg.snap};
            end
            `RTC_ADR_OSC: begin
                s_next.rdata = {s_reg.agc, s_reg.xtal, s_reg.bias,
                                s_reg.valid_f, 3'h0, s_reg.vbat_f};
            end
            default: begin
                for (int i = 0; i < `RTC_NBYTES; i++) begin
                    if (s_reg.idx == `RTC_ADR_CAP0 + 8'(i)) begin
                        s_next.rdata = s_reg.cap[i];
                    end
                    if (s_reg.idx == `RTC_ADR_ALM0 + 8'(i)) begin
                        s_next.rdata = s_reg.alm[i];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s_reg     <= '0;
            s_reg.cap <= {`RTC_NBYTES{`RTC_BYTE_RST}};
            s_reg.alm <= {`RTC_NBYTES{`RTC_BYTE_RST}};
        end else begin
            s_reg <= s_next;
        end
    end

    // ==================================================
    // outputs
    assign data_out                = s_reg.rdata;
    assign rtc_enable_out          = s_reg.en;
    assign gain_control_enable_out = s_reg.agc;
    assign crystal_select_out      = s_reg.xtal;
    assign bias_double_out         = s_reg.bias;
    assign irq_req_out   = s_reg.flag & irq_enable_in;
    assign mcu_reset_out = s_reg.alarm_evt & reset_source_in;
    assign osc_wake_out  = s_reg.alarm_evt;

    // ==================================================
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    property p_run_count;
        tick && s_reg.run && !s_reg.load |=>
            timer_val == $past(timer_val) + 47'h1;
    endproperty
    a_run_count: assert property (p_run_count)
        else $error("timer did not count on tick");

    property p_hold;
        (!tick || (!s_reg.run && !s_reg.load)) |=>
            timer_val == $past(timer_val);
    endproperty
    a_hold: assert property (p_hold)
        else $error("timer moved without cause");

    property p_snap_running;
        tick && s_reg.snap && s_reg.run && !s_reg.load |=>
            timer_val == $past(timer_val) + 47'h1 &&
            cap_flat[47:1] == $past(timer_val);
    endproperty
    a_snap_running: assert property (p_snap_running)
        else $error("snapshot disturbed running timer");

    property p_load;
        tick && s_reg.load |=> timer_val == $past(cap_flat[47:1]) &&
            !s_reg.load;
    endproperty
    a_load: assert property (p_load)
        else $error("load did not take snapshot bytes");

    property p_load_wait;
        s_reg.load && !tick |=> s_reg.load;
    endproperty
    a_load_wait: assert property (p_load_wait)
        else $error("load strobe cleared before load");

    property p_snap;
        tick && s_reg.snap |=> cap_flat == {$past(timer_val), 1'b0} &&
            !s_reg.snap;
    endproperty
    a_snap: assert property (p_snap)
        else $error("snapshot bytes wrong after capture");

    property p_alarm_flag;
        s_reg.aen && (timer_val >= alm_flat[47:1]) |=>
            s_reg.flag && osc_wake_out;
    endproperty
    a_alarm_flag: assert property (p_alarm_flag)
        else $error("alarm event missed");

    property p_no_alarm;
        !s_reg.aen |=> !osc_wake_out;
    endproperty
    a_no_alarm: assert property (p_no_alarm)
        else $error("alarm event while disabled");

    property p_alarm_out;
        s_reg.aen && (timer_val >= alm_flat[47:1]) ##1
            (irq_enable_in && reset_source_in) |->
            irq_req_out && mcu_reset_out;
    endproperty
    a_alarm_out: assert property (p_alarm_out)
        else $error("alarm did not request irq and reset");

    property p_osc_unused;
        s_reg.idx == `RTC_ADR_OSC && !index_wr_in |=> data_out[3:1] == 3'h0;
    endproperty
    a_osc_unused: assert property (p_osc_unused)
        else $error("unused oscillator bits not zero");

    c_load: cover property (tick && s_reg.load);
    c_snap: cover property (tick && s_reg.snap && s_reg.run);
    c_alarm: cover property ($rose(s_reg.flag));
    c_irq: cover property (irq_req_out && mcu_reset_out);
endmodule

// ---- hdl/rtc_params.svh ----
// constants of the real-time timer and alarm core
// assumes a 10 MHz system clock and a 32768 Hz real-time tick
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// ==================================================
// register indices behind the indirect pair
`define RTC_ADR_CAP0   8'h00
`define RTC_ADR_CTRL   8'h06
`define RTC_ADR_OSC    8'h07
`define RTC_ADR_ALM0   8'h08
`define RTC_NBYTES     6
`define RTC_BYTE_RST   8'hFF
`define RTC_ZERO_BYTE  8'h00

// ==================================================
// control register bits
`define RTC_CTL_EN     7
`define RTC_CTL_MCLK   6
`define RTC_CTL_RUN    4
`define RTC_CTL_AEN    3
`define RTC_CTL_FLAG   2
`define RTC_CTL_LOAD   1
`define RTC_CTL_SNAP   0

// ==================================================
// oscillator control bits
`define RTC_OSC_AGC    7
`define RTC_OSC_XTAL   6
`define RTC_OSC_BIAS   5
`define RTC_OSC_VALID  4
`define RTC_OSC_VBAT   0

// ==================================================
// timing
`define RTC_SYS_HZ     10000000
`define RTC_SLOW_HZ    32768
`define RTC_DIV        (`RTC_SYS_HZ / `RTC_SLOW_HZ)

`endif

// ---- hdl/rtc_pkg.sv ----
// types shared by the real-time timer and alarm core
// assumes nothing beyond the parameter header
package rtc_pkg;
    typedef logic [7:0]       byte_t;
    typedef logic [46:0]      timer_val_t;
    typedef logic [5:0][7:0]  byte_bank_t;
endpackage

// ---- hdl/rtc_tick_timer.sv ----
// slow tick divider and the 47-bit running timer
// assumes an asynchronous active-low reset from the parent
`timescale 1ns/100ps
`include "rtc_params.svh"

module rtc_tick_timer #(
    parameter int DIV = `RTC_DIV
) (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              run_in,
    input  wire logic              load_in,
    input  wire rtc_pkg::timer_val_t load_val_in,
    output logic                   tick_out,
    output rtc_pkg::timer_val_t    count_out
);
    import rtc_pkg::*;

    localparam int DW = $clog2(DIV);

    typedef struct packed {
        logic [DW-1:0] div;
        logic          tick;
        timer_val_t    cnt;
    } tmr_state_t;

    tmr_state_t s_reg;
    tmr_state_t s_next;

    // ==================================================
    // next state
    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (s_reg.div == DW'(DIV - 1)) begin
            s_next.div  = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.div = s_reg.div + 1'b1;
        end
        // load wins over counting on the same tick
        if (s_reg.tick) begin
            if (load_in) begin
                s_next.cnt = load_val_in;
            end else if (run_in) begin
                s_next.cnt = s_reg.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick_out  = s_reg.tick;
    assign count_out = s_reg.cnt;
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the real-time timer and alarm core
// assumes the core's own assertions; drives the index/data pair directly
`timescale 1ns/100ps
`include "rtc_params.svh"

module tb;
    import rtc_pkg::*;
    // ==================================================
    // clock, reset, ports
    localparam int DIV = 4;
    logic  clk_in;
    logic  arst_n_in;
    logic  index_wr_in;
    logic  data_wr_in;
    byte_t index_in;
    byte_t data_in;
    byte_t data_out;
    logic  irq_enable_in;
    logic  reset_source_in;
    logic  osc_valid_in;
    logic  backup_supply_in;
    logic  rtc_enable_out;
    logic  gain_control_enable_out;
    logic  crystal_select_out;
    logic  bias_double_out;
    logic  irq_req_out;
    logic  mcu_reset_out;
    logic  osc_wake_out;
    int    mismatches;
    int    checked;
    logic [47:0] a;
    logic [47:0] b;
    byte_t v;

    rtc_timer_alarm_core #(.DIV(DIV)) rtc_timer_alarm_core_i (
        .clk_in                  (clk_in),
        .arst_n_in               (arst_n_in),
        .index_wr_in             (index_wr_in),
        .index_in                (index_in),
        .data_wr_in              (data_wr_in),
        .data_in                 (data_in),
        .data_out                (data_out),
        .irq_enable_in           (irq_enable_in),
        .reset_source_in         (reset_source_in),
        .osc_valid_in            (osc_valid_in),
        .backup_supply_in        (backup_supply_in),
        .rtc_enable_out          (rtc_enable_out),
        .gain_control_enable_out (gain_control_enable_out),
        .crystal_select_out      (crystal_select_out),
        .bias_double_out         (bias_double_out),
        .irq_req_out             (irq_req_out),
        .mcu_reset_out           (mcu_reset_out),
        .osc_wake_out            (osc_wake_out)
    );

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // ==================================================
    // shared tasks
    task automatic chk(input string name, input logic [47:0] seen,
                       input logic [47:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input byte_t idx, input byte_t val);
        @(negedge clk_in);
        index_wr_in = 1'b1;
        index_in    = idx;
        @(negedge clk_in);
        index_wr_in = 1'b0;
        data_wr_in  = 1'b1;
        data_in     = val;
        @(negedge clk_in);
        data_wr_in  = 1'b0;
    endtask

    // data_out follows the index one cycle late
    task automatic rd(input byte_t idx, output byte_t val);
        @(negedge clk_in);
        index_wr_in = 1'b1;
        index_in    = idx;
        @(negedge clk_in);
        index_wr_in = 1'b0;
        @(negedge clk_in);
        val = data_out;
    endtask

    task automatic poll(input int bitn);
        byte_t r;
        int    n;
        n = 0;
        rd(8'h06, r);
        while (r[bitn] !== 1'b0 && n < 60) begin
            rd(8'h06, r);
            n++;
        end
        chk("strobe self clear", 48'(r[bitn]), 48'h0);
    endtask

    task automatic put_bank(input byte_t base, input logic [47:0] val);
        for (int i = 0; i < 6; i++)
            wr(base + 8'(i), val[8*i +: 8]);
    endtask

    task automatic take(input byte_t ctl, output logic [47:0] val);
        byte_t r;
        wr(8'h06, ctl);
        poll(0);
        for (int i = 0; i < 6; i++) begin
            rd(8'(i), r);
            val[8*i +: 8] = r;
        end
    endtask

    // ==================================================
    // scenarios
    task automatic t_reset_and_osc();
        take(8'h00, a);
        chk("snapshot reset", a, 48'hFFFF_FFFF_FFFF);
        wr(8'h20, 8'h5A);
        rd(8'h20, v);
        chk("unmapped read", 48'(v), 48'h0);
        // spare control bit is stored, bit 5 always reads zero
        wr(8'h06, 8'h60);
        rd(8'h06, v);
        chk("control spare", 48'(v), 48'h40);
        osc_valid_in     = 1'b1;
        backup_supply_in = 1'b1;
        wr(8'h07, 8'hFF);
        repeat (8) @(negedge clk_in);
        rd(8'h07, v);
        chk("osc readback", 48'(v), 48'hF1);
        chk("osc outputs", 48'({gain_control_enable_out, crystal_select_out,
            bias_double_out}), 48'h7);
        osc_valid_in     = 1'b0;
        backup_supply_in = 1'b0;
        wr(8'h07, 8'h0E);
        repeat (8) @(negedge clk_in);
        rd(8'h07, v);
        chk("osc cleared", 48'(v), 48'h00);
    endtask

    task automatic t_load_snapshot();
        // bit 0 of byte 0 set on purpose: must not reach the timer
        put_bank(8'h00, {47'h5A5A_1234_5678, 1'b1});
        wr(8'h06, 8'h82);
        poll(1);
        chk("enable out", 48'(rtc_enable_out), 48'h1);
        take(8'h81, a);
        chk("load value", a, {47'h5A5A_1234_5678, 1'b0});
        repeat (20) @(negedge clk_in);
        take(8'h81, b);
        chk("timer holds", b, a);
    endtask

    task automatic t_running();
        put_bank(8'h00, {47'h0000_0000_1000, 1'b0});
        wr(8'h06, 8'h92);
        poll(1);
        // two ticks at least, else the capture may still show the load
        repeat (8) @(negedge clk_in);
        take(8'h91, a);
        chk("runs up", 48'(a[47:1] > 47'h1000 && a[47:1] < 47'h1100),
            48'h1);
        take(8'h81, a);
        repeat (20) @(negedge clk_in);
        take(8'h81, b);
        chk("stopped holds", b, a);
    endtask

    task automatic t_alarm();
        logic [46:0] tgt [4];
        logic        hit [4];
        tgt = '{47'h0FF, 47'h100, 47'h101, 47'h7FFF_FFFF_FFFF};
        hit = '{1'b1, 1'b1, 1'b0, 1'b0};
        irq_enable_in   = 1'b1;
        reset_source_in = 1'b1;
        put_bank(8'h00, {47'h100, 1'b0});
        wr(8'h06, 8'h82);
        poll(1);
        for (int i = 0; i < 4; i++) begin
            // disable first so a half-written target cannot fire
            wr(8'h06, 8'h80);
            put_bank(8'h08, {tgt[i], 1'b0});
            repeat (4) @(negedge clk_in);
            chk("no event when off", 48'(osc_wake_out), 48'h0);
            wr(8'h06, 8'h88);
            repeat (4) @(negedge clk_in);
            chk("wake", 48'(osc_wake_out), 48'(hit[i]));
            chk("irq", 48'(irq_req_out), 48'(hit[i]));
            chk("mcu reset", 48'(mcu_reset_out), 48'(hit[i]));
            rd(8'h06, v);
            chk("flag", 48'(v[2]), 48'(hit[i]));
        end
        // event then parking: flag stays set until software clears it
        wr(8'h06, 8'h80);
        put_bank(8'h08, {47'h0FF, 1'b0});
        wr(8'h06, 8'h88);
        repeat (4) @(negedge clk_in);
        irq_enable_in   = 1'b0;
        reset_source_in = 1'b0;
        @(negedge clk_in);
        chk("irq masked", 48'(irq_req_out), 48'h0);
        chk("reset deselected", 48'(mcu_reset_out), 48'h0);
        chk("wake held", 48'(osc_wake_out), 48'h1);
        rd(8'h06, v);
        chk("flag held", 48'(v[2]), 48'h1);
        wr(8'h06, 8'h80);
        put_bank(8'h08, 48'hFFFF_FFFF_FFFF);
        wr(8'h06, 8'h88);
        repeat (4) @(negedge clk_in);
        rd(8'h06, v);
        chk("flag parked", 48'(v[2]), 48'h0);
        chk("wake parked", 48'(osc_wake_out), 48'h0);
    endtask

    // ==================================================
    // main sequence and watchdog
    initial begin
        mismatches       = 0;
        checked          = 0;
        arst_n_in        = 1'b0;
        index_wr_in      = 1'b0;
        data_wr_in       = 1'b0;
        index_in         = 8'h00;
        data_in          = 8'h00;
        irq_enable_in    = 1'b0;
        reset_source_in  = 1'b0;
        osc_valid_in     = 1'b0;
        backup_supply_in = 1'b0;
        repeat (8) @(negedge clk_in);
        arst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        t_reset_and_osc();
        t_load_snapshot();
        t_running();
        t_alarm();
        close_out();
    end

    // whole run needs several hundred cycles; allow ample margin
    initial begin
        repeat (40000) @(posedge clk_in);
        mismatches++;
        close_out();
    end
endmodule
